// ==== src/link_stats_regs.svh ====
// register map, field positions and fixed values of the link statistics block
// assumes 32-bit AXI4-Lite data, one register per aligned word
`ifndef LINK_STATS_REGS_SVH
`define LINK_STATS_REGS_SVH
`define OFS_CTRL 8'h00
`define OFS_LINE_OUT 8'h04
`define OFS_LINE_IN 8'h08
`define OFS_LINE_BAD 8'h0C
`define OFS_LINE_RATIO 8'h10
`define OFS_RADIO_NACK 8'h14
`define OFS_RADIO_TX 8'h18
`define OFS_RADIO_RX 8'h1C
`define OFS_RADIO_BAD 8'h20
`define OFS_RADIO_LOST 8'h24
`define OFS_RADIO_RATIO 8'h28
`define OFS_RESET_CNT 8'h2C
`define CTRL_RATE_LSB 0
`define CTRL_RATE_MSB 1
`define CTRL_CLR_STATS 4
`define CTRL_CLR_RESETS 5
`define LEN_HALF 9'h028
`define LEN_1M 9'h05C
`define LEN_2M 9'h0C4
`define LEN_3M 9'h12C
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h1021
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CNT_LINE_OUT 0
`define CNT_LINE_IN 1
`define CNT_LINE_BAD 2
`define CNT_RADIO_NACK 3
`define CNT_RADIO_TX 4
`define CNT_RADIO_RX 5
`define CNT_RADIO_BAD 6
`define CNT_RADIO_LOST 7
`define CNT_NUM 8
`define IDX_CTRL 4'h0
`define IDX_LINE_RATIO 4'h4
`define IDX_RADIO_RATIO 4'hA
`define IDX_RESET_CNT 4'hB
`define IDX_NONE 4'hF
`endif

// ==== src/link_stats_pkg.sv ====
// types shared by the link statistics block
// assumes nothing beyond a SystemVerilog compiler
package link_stats_pkg;
   typedef enum logic [1:0] {rate_half, rate_1m, rate_2m, rate_3m} rate_e;
   typedef enum logic {div_load, div_run} div_state_e;
   typedef logic [3:0] reg_idx_t;
endpackage

// ==== src/arq_link_statistics.sv ====
// fragment statistics of a radio link with retransmission on error
// assumes AXI4-Lite master on aclk; event inputs are one-cycle pulses
`timescale 1ns/1ps
`include "link_stats_regs.svh"
module arq_link_statistics #(
   parameter int CW = 32,
   parameter int RW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic por_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_in_valid,
   input wire logic [7:0] line_in_byte,
   output logic frag_done_r,
   output logic [7:0] frag_id_r,
   output logic [15:0] frag_crc_r,
   output logic hdr_ack_ok_r,
   output logic [7:0] hdr_ack_id_r,
   input wire logic line_out_ev,
   input wire logic line_out_bad,
   input wire logic radio_tx_ev,
   input wire logic radio_nack_ev,
   input wire logic [7:0] radio_nack_id,
   input wire logic rx_frag_valid,
   input wire logic [7:0] rx_frag_id,
   input wire logic rx_crc_ok,
   input wire logic radio_lost_ev,
   output logic retx_req_r,
   output logic [7:0] retx_id_r,
   output logic tracer_clear_r
);

   // ---------------------------------------------------------------
   // decoding
   // ---------------------------------------------------------------
   function automatic link_stats_pkg::reg_idx_t reg_index(input logic [7:0] a);
      reg_index = `IDX_NONE;
      if (a[1:0] == 2'h0 && a <= `OFS_RESET_CNT) begin
         reg_index = link_stats_pkg::reg_idx_t'(a[7:2]);
      end
   endfunction

   function automatic logic [8:0] frag_len(input link_stats_pkg::rate_e r);
      unique case (r)
         link_stats_pkg::rate_half: frag_len = `LEN_HALF;
         link_stats_pkg::rate_1m: frag_len = `LEN_1M;
         link_stats_pkg::rate_2m: frag_len = `LEN_2M;
         link_stats_pkg::rate_3m: frag_len = `LEN_3M;
      endcase
   endfunction

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         x = x[15] ? ({x[14:0], 1'b0} ^ `CRC_POLY) : {x[14:0], 1'b0};
      end
      crc_byte = x;
   endfunction

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_fire;
   link_stats_pkg::reg_idx_t wr_idx;
   link_stats_pkg::rate_e rate_r;
   logic clr_stats_r;
   logic clr_resets_r;
   logic [CW-1:0] cnt_r [`CNT_NUM];
   logic [RW-1:0] line_ratio_r;
   logic [RW-1:0] radio_ratio_r;
   logic [CW-1:0] reset_cnt_r;

   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_idx = reg_index(awaddr_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // control register: rate field and self-clearing clear commands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rate_r <= link_stats_pkg::rate_1m;
         clr_stats_r <= 1'b0;
         clr_resets_r <= 1'b0;
      end else if (ce) begin
         clr_stats_r <= 1'b0;
         clr_resets_r <= 1'b0;
         if (wr_fire && wr_idx == `IDX_CTRL && wstrb_r[0]) begin
            rate_r <= link_stats_pkg::rate_e'(wdata_r[`CTRL_RATE_MSB:`CTRL_RATE_LSB]);
            clr_stats_r <= wdata_r[`CTRL_CLR_STATS];
            clr_resets_r <= wdata_r[`CTRL_CLR_RESETS];
         end
      end
   end

   function automatic logic [31:0] rd_mux(input link_stats_pkg::reg_idx_t i);
      rd_mux = 32'h0000_0000;
      if (i == `IDX_CTRL) begin
         rd_mux[`CTRL_RATE_MSB:`CTRL_RATE_LSB] = rate_r;
      end else if (i == `IDX_LINE_RATIO) begin
         rd_mux[RW-1:0] = line_ratio_r;
      end else if (i == `IDX_RADIO_RATIO) begin
         rd_mux[RW-1:0] = radio_ratio_r;
      end else if (i == `IDX_RESET_CNT) begin
         rd_mux[CW-1:0] = reset_cnt_r;
      end else if (i != `IDX_NONE) begin
         rd_mux[CW-1:0] = cnt_r[i < `IDX_LINE_RATIO ? 3'(i - 4'h1) : 3'(i - 4'h2)];
      end
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux(reg_index(s_axi_araddr));
            s_axi_rresp <= (reg_index(s_axi_araddr) == `IDX_NONE) ?
                           `RESP_SLVERR : `RESP_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // segmenter with crc
   // ---------------------------------------------------------------
   logic [8:0] byte_cnt_r;
   logic [15:0] crc_r;
   logic [7:0] next_id_r;
   logic [15:0] crc_nxt;
   logic last_byte;

   assign crc_nxt = crc_byte(crc_r, line_in_byte);
   assign last_byte = byte_cnt_r >= frag_len(rate_r) - 9'h001;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         byte_cnt_r <= 9'h000;
         crc_r <= `CRC_INIT;
         next_id_r <= 8'h00;
         frag_done_r <= 1'b0;
         frag_id_r <= 8'h00;
         frag_crc_r <= 16'h0000;
      end else if (ce) begin
         frag_done_r <= 1'b0;
         if (line_in_valid) begin
            if (last_byte) begin
               byte_cnt_r <= 9'h000;
               crc_r <= `CRC_INIT;
               frag_done_r <= 1'b1;
               frag_crc_r <= crc_nxt;
               frag_id_r <= next_id_r;
               next_id_r <= next_id_r + 8'h01;
            end else begin
               byte_cnt_r <= byte_cnt_r + 9'h001;
               crc_r <= crc_nxt;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // acknowledge and retransmit
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hdr_ack_ok_r <= 1'b0;
         hdr_ack_id_r <= 8'h00;
         retx_req_r <= 1'b0;
         retx_id_r <= 8'h00;
      end else if (ce) begin
         retx_req_r <= radio_nack_ev;
         if (radio_nack_ev) begin
            retx_id_r <= radio_nack_id;
         end
         if (rx_frag_valid) begin
            hdr_ack_ok_r <= rx_crc_ok;
            hdr_ack_id_r <= rx_frag_id;
         end
      end
   end

   // ---------------------------------------------------------------
   // fragment counters
   // ---------------------------------------------------------------
   logic [`CNT_NUM-1:0] ev;

   always_comb begin
      ev = '0;
      ev[`CNT_LINE_OUT] = line_out_ev;
      ev[`CNT_LINE_IN] = frag_done_r;
      ev[`CNT_LINE_BAD] = line_out_ev && line_out_bad;
      ev[`CNT_RADIO_NACK] = radio_nack_ev;
      ev[`CNT_RADIO_TX] = radio_tx_ev;
      ev[`CNT_RADIO_RX] = rx_frag_valid;
      ev[`CNT_RADIO_BAD] = (rx_frag_valid && !rx_crc_ok) || radio_lost_ev;
      ev[`CNT_RADIO_LOST] = radio_lost_ev;
   end

   for (genvar g = 0; g < `CNT_NUM; g++) begin : g_cnt
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cnt_r[g] <= '0;
         end else if (ce) begin
            if (clr_stats_r) begin
               cnt_r[g] <= CW'(ev[g]);
            end else if (ev[g] && cnt_r[g] != '1) begin
               cnt_r[g] <= cnt_r[g] + CW'(1);
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tracer_clear_r <= 1'b0;
      end else if (ce) begin
         tracer_clear_r <= clr_stats_r;
      end
   end

   // ---------------------------------------------------------------
   // reset counter, kept across aresetn
   // ---------------------------------------------------------------
   logic in_reset_r;

   always_ff @(posedge aclk) begin
      if (!por_n) begin
         reset_cnt_r <= '0;
         in_reset_r <= 1'b0;
      end else begin
         in_reset_r <= !aresetn;
         if (!aresetn && !in_reset_r && reset_cnt_r != '1) begin
            reset_cnt_r <= reset_cnt_r + CW'(1);
         end else if (aresetn && ce && clr_resets_r) begin
            reset_cnt_r <= '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // ratio divider, alternates line and radio
   // ---------------------------------------------------------------
   link_stats_pkg::div_state_e div_st_r;
   logic div_sel_r;
   logic [CW:0] rem_r;
   logic [CW-1:0] den_r;
   logic [RW-1:0] quo_r;
   logic [4:0] bit_cnt_r;
   logic [CW-1:0] num_ld;
   logic [CW-1:0] den_ld;
   logic [CW:0] rem_sh;

   assign num_ld = div_sel_r ? cnt_r[`CNT_RADIO_BAD] : cnt_r[`CNT_LINE_BAD];
   assign den_ld = div_sel_r ? cnt_r[`CNT_RADIO_RX] : cnt_r[`CNT_LINE_OUT];
   assign rem_sh = {rem_r[CW-1:0], 1'b0};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_st_r <= link_stats_pkg::div_load;
         div_sel_r <= 1'b0;
         rem_r <= '0;
         den_r <= '0;
         quo_r <= '0;
         bit_cnt_r <= 5'h00;
         line_ratio_r <= '0;
         radio_ratio_r <= '0;
      end else if (ce) begin
         unique case (div_st_r)
            link_stats_pkg::div_load: begin
               if (den_ld == '0 || num_ld >= den_ld) begin
                  div_sel_r <= !div_sel_r;
                  if (div_sel_r) begin
                     radio_ratio_r <= (den_ld == '0) ? '0 : '1;
                  end else begin
                     line_ratio_r <= (den_ld == '0) ? '0 : '1;
                  end
               end else begin
                  rem_r <= {1'b0, num_ld};
                  den_r <= den_ld;
                  bit_cnt_r <= 5'(RW - 1);
                  div_st_r <= link_stats_pkg::div_run;
               end
            end
            link_stats_pkg::div_run: begin
               if (rem_sh >= {1'b0, den_r}) begin
                  rem_r <= rem_sh - {1'b0, den_r};
                  quo_r <= {quo_r[RW-2:0], 1'b1};
               end else begin
                  rem_r <= rem_sh;
                  quo_r <= {quo_r[RW-2:0], 1'b0};
               end
               if (bit_cnt_r == 5'h00) begin
                  div_st_r <= link_stats_pkg::div_load;
                  div_sel_r <= !div_sel_r;
                  if (div_sel_r) begin
                     radio_ratio_r <= {quo_r[RW-2:0], rem_sh >= {1'b0, den_r}};
                  end else begin
                     line_ratio_r <= {quo_r[RW-2:0], rem_sh >= {1'b0, den_r}};
                  end
               end else begin
                  bit_cnt_r <= bit_cnt_r - 5'h01;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence ctrl_clear_s;
      ce && wr_fire && wr_idx == `IDX_CTRL && wstrb_r[0] && wdata_r[`CTRL_CLR_STATS];
   endsequence

   cnt_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_clear_s ##1 ce |=> cnt_r[`CNT_RADIO_TX] <= CW'(1))
      else $error("counter not cleared");
   cnt_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cnt_r[`CNT_RADIO_RX] == '1 && !clr_stats_r |=> cnt_r[`CNT_RADIO_RX] == '1)
      else $error("counter wrapped");
   cnt_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && radio_tx_ev && !clr_stats_r && cnt_r[`CNT_RADIO_TX] != '1 |=>
      cnt_r[`CNT_RADIO_TX] == $past(cnt_r[`CNT_RADIO_TX]) + CW'(1))
      else $error("radio tx not counted");
   lost_bad_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && radio_lost_ev && !clr_stats_r && cnt_r[`CNT_RADIO_BAD] != '1 |=>
      cnt_r[`CNT_RADIO_BAD] != $past(cnt_r[`CNT_RADIO_BAD]))
      else $error("lost fragment not counted as bad");
   zero_ratio_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && div_st_r == link_stats_pkg::div_load && !div_sel_r && den_ld == '0
      |=> line_ratio_r == '0)
      else $error("ratio not zero on zero divisor");
   frag_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      frag_done_r |-> $past(byte_cnt_r) == frag_len(rate_r) - 9'h001 || $past(byte_cnt_r)
      >= frag_len(rate_r))
      else $error("fragment length wrong");
   nak_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && rx_frag_valid |=> hdr_ack_ok_r == $past(rx_crc_ok) &&
      hdr_ack_id_r == $past(rx_frag_id))
      else $error("ack header wrong");
   bresp_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && wr_fire |=> s_axi_bvalid ##0 s_axi_bvalid [*1])
      else $error("write response missing");
   rresp_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response missing");
   reset_cnt_a: assert property (@(posedge aclk) disable iff (!por_n)
      !aresetn && !in_reset_r && reset_cnt_r != '1 |=>
      reset_cnt_r == $past(reset_cnt_r) + CW'(1))
      else $error("reset not counted");

endmodule

// ==== tb/remote_peer.sv ====
// remote modem on the far side of the radio link
// assumes tb pulses send_req or nack_req for one cycle at a time
`timescale 1ns/1ps
module remote_peer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic send_req,
   input wire logic [1:0] send_kind,
   input wire logic [7:0] send_id,
   input wire logic nack_req,
   input wire logic hdr_ack_ok_r,
   input wire logic [7:0] hdr_ack_id_r,
   output logic rx_frag_valid,
   output logic [7:0] rx_frag_id,
   output logic rx_crc_ok,
   output logic radio_lost_ev,
   output logic radio_nack_ev,
   output logic [7:0] radio_nack_id
);
   logic pend_r;
   logic [7:0] pend_id_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_frag_valid <= 1'b0;
         rx_frag_id <= 8'h00;
         rx_crc_ok <= 1'b0;
         radio_lost_ev <= 1'b0;
         radio_nack_ev <= 1'b0;
         radio_nack_id <= 8'h00;
         pend_r <= 1'b0;
         pend_id_r <= 8'h00;
      end else begin
         // idle id and crc lines toggle, valid and event lines stay low, so stale values never look valid
         rx_frag_valid <= 1'b0;
         rx_frag_id <= ~rx_frag_id;
         rx_crc_ok <= ~rx_crc_ok;
         radio_lost_ev <= 1'b0;
         radio_nack_ev <= nack_req;
         radio_nack_id <= nack_req ? send_id : ~radio_nack_id;
         if (send_req && send_kind == 2'h2) begin
            radio_lost_ev <= 1'b1;
         end else if (send_req) begin
            rx_frag_valid <= 1'b1;
            rx_frag_id <= send_id;
            rx_crc_ok <= (send_kind == 2'h0);
            pend_r <= (send_kind == 2'h1);
            pend_id_r <= send_id;
         end else if (pend_r && hdr_ack_ok_r == 1'b0 && hdr_ack_id_r == pend_id_r) begin
            // resend the fragment the block refused
            rx_frag_valid <= 1'b1;
            rx_frag_id <= pend_id_r;
            rx_crc_ok <= 1'b1;
            pend_r <= 1'b0;
         end
      end
   end
endmodule

// ==== tb/tb.sv ====
// self-checking bench of the link statistics block
// assumes the remote_peer model and the register header
`timescale 1ns/1ps
`include "link_stats_regs.svh"
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic por_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic line_in_valid = 1'b0;
   logic [7:0] line_in_byte = 8'h00;
   logic frag_done_r, hdr_ack_ok_r, retx_req_r, tracer_clear_r;
   logic [7:0] frag_id_r, hdr_ack_id_r, retx_id_r, rx_frag_id, radio_nack_id;
   logic [15:0] frag_crc_r;
   logic line_out_ev = 1'b0;
   logic line_out_bad = 1'b0;
   logic radio_tx_ev = 1'b0;
   logic radio_nack_ev, rx_frag_valid, rx_crc_ok, radio_lost_ev;
   logic send_req = 1'b0;
   logic nack_req = 1'b0;
   logic [1:0] send_kind = 2'h0;
   logic [7:0] send_id = 8'h00;
   logic [1:0] resp;
   logic [31:0] rdat;
   logic [15:0] ecrc;
   logic [8:0] lens [4] = '{`LEN_HALF, `LEN_1M, `LEN_2M, `LEN_3M};
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   int dn = 0;
   int clr = 0;
   int rtx = 0;
   int d0;
   arq_link_statistics u_arq_link_statistics (.aclk, .aresetn, .ce, .por_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .line_in_valid, .line_in_byte, .frag_done_r,
      .frag_id_r, .frag_crc_r, .hdr_ack_ok_r, .hdr_ack_id_r, .line_out_ev,
      .line_out_bad, .radio_tx_ev, .radio_nack_ev, .radio_nack_id, .rx_frag_valid,
      .rx_frag_id, .rx_crc_ok, .radio_lost_ev, .retx_req_r, .retx_id_r,
      .tracer_clear_r);
   remote_peer u_remote_peer (.aclk, .aresetn, .send_req, .send_kind, .send_id,
      .nack_req, .hdr_ack_ok_r, .hdr_ack_id_r, .rx_frag_valid, .rx_frag_id,
      .rx_crc_ok, .radio_lost_ev, .radio_nack_ev, .radio_nack_id);
   initial forever #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (frag_done_r === 1'b1) dn <= dn + 1;
      if (tracer_clear_r === 1'b1) clr <= clr + 1;
      if (retx_req_r === 1'b1) rtx <= rtx + 1;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task complete_run();
      if (fails == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      rd(a);
      chk(nm, e, rdat);
      chk("rresp", {30'h0, `RESP_OKAY}, {30'h0, resp});
   endtask
   task ev(input int k);
      line_out_ev <= (k < 2);
      line_out_bad <= (k == 1);
      radio_tx_ev <= (k == 2);
      @(posedge aclk);
      line_out_ev <= 1'b0;
      radio_tx_ev <= 1'b0;
      @(posedge aclk);
   endtask
   task rs(input logic [1:0] kind, input logic [7:0] id, input logic nk);
      send_req <= !nk;
      nack_req <= nk;
      send_kind <= kind;
      send_id <= id;
      @(posedge aclk);
      send_req <= 1'b0;
      nack_req <= 1'b0;
      repeat (12) @(posedge aclk);
   endtask
   task frag(input int lo, input int hi);
      for (int i = lo; i <= hi; i++) begin
         line_in_valid <= 1'b1;
         line_in_byte <= 8'(i);
         for (int b = 7; b >= 0; b--) begin
            ecrc = ecrc[15] ^ i[b] ? {ecrc[14:0], 1'b0} ^ `CRC_POLY : {ecrc[14:0], 1'b0};
         end
         @(posedge aclk);
      end
      line_in_valid <= 1'b0;
      line_in_byte <= ~line_in_byte;
      repeat (2) @(posedge aclk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge aclk);
      por_n <= 1'b1;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(`OFS_CTRL, 32'h00000001, "ctrl reset");
      for (int a = 4; a <= 40; a += 4) rc(8'(a), 32'h00000000, "reset count");
      foreach (lens[i]) begin
         rd(8'h30 - 8'(i * 43));
         chk("bad addr resp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
         chk("bad addr data", 32'h00000000, rdat);
      end
      wr(8'h31, 32'h00000001);
      chk("bad addr bresp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
      rc(`OFS_RESET_CNT, 32'h00000001, "resets at start");
      wr(`OFS_CTRL, 32'h00000021);
      rc(`OFS_RESET_CNT, 32'h00000000, "resets cleared");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(`OFS_RESET_CNT, 32'h00000001, "resets counted");
      por_n <= 1'b0;
      @(posedge aclk);
      por_n <= 1'b1;
      @(posedge aclk);
      rc(`OFS_RESET_CNT, 32'h00000000, "resets por");
      for (int i = 0; i < 4; i++) ev(i == 2 ? 1 : 0);
      repeat (80) @(posedge aclk);
      rc(`OFS_LINE_OUT, 32'h00000004, "line out");
      rc(`OFS_LINE_BAD, 32'h00000001, "line bad");
      rc(`OFS_LINE_RATIO, 32'h00004000, "line ratio");
      for (int i = 1; i <= 3; i++) begin
         rs(2'h0, 8'(i), 1'b0);
         ev(2);
      end
      rs(2'h1, 8'h04, 1'b0);
      repeat (20) @(posedge aclk);
      chk("ack ok", 32'h00000001, {31'h0, hdr_ack_ok_r});
      chk("ack id", 32'h00000004, {24'h0, hdr_ack_id_r});
      rs(2'h2, 8'h05, 1'b0);
      rs(2'h0, 8'h06, 1'b1);
      chk("retx req", 32'h00000001, 32'(rtx));
      chk("retx id", 32'h00000006, {24'h0, retx_id_r});
      ev(2);
      repeat (80) @(posedge aclk);
      rc(`OFS_RADIO_RX, 32'h00000005, "radio rx");
      rc(`OFS_RADIO_BAD, 32'h00000002, "radio bad");
      rc(`OFS_RADIO_LOST, 32'h00000001, "radio lost");
      rc(`OFS_RADIO_NACK, 32'h00000001, "radio nack");
      rc(`OFS_RADIO_TX, 32'h00000004, "radio tx");
      rc(`OFS_RADIO_RATIO, 32'h00006666, "radio ratio");
      foreach (lens[r]) begin
         wr(`OFS_CTRL, 32'(r));
         rc(`OFS_CTRL, 32'(r), "rate");
         ecrc = `CRC_INIT;
         d0 = dn;
         frag(0, int'(lens[r]) - 2);
         chk("early done", 32'(d0), 32'(dn));
         frag(int'(lens[r]) - 1, int'(lens[r]) - 1);
         chk("frag done", 32'(d0 + 1), 32'(dn));
         chk("frag crc", {16'h0, ecrc}, {16'h0, frag_crc_r});
         chk("frag id", 32'(r), {24'h0, frag_id_r});
         rc(`OFS_LINE_IN, 32'(r + 1), "line in");
      end
      wr(`OFS_LINE_IN, 32'h000000FF);
      rc(`OFS_LINE_IN, 32'h00000004, "count kept");
      ce <= 1'b0;
      ev(2);
      ce <= 1'b1;
      rc(`OFS_RADIO_TX, 32'h00000004, "tx frozen");
      d0 = clr;
      wr(`OFS_CTRL, 32'h00000013);
      repeat (80) @(posedge aclk);
      chk("tracer clear", 32'(d0 + 1), 32'(clr));
      for (int a = 4; a <= 40; a += 4) rc(8'(a), 32'h00000000, "cleared");
      rc(`OFS_CTRL, 32'h00000003, "ctrl after clear");
      complete_run();
   end
endmodule
